//--- design/tx_sum_pkg.sv
// constants, field layout and states of the transmit checksum offload engine
package tx_sum_pkg;
	// register bus
	localparam int ADR_W = 8;
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_MODE_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// command word flags
	localparam int CMD_A_FIRST_SEG_BIT = 13;
	localparam int CMD_B_SUM_REQ_BIT = 14;
	// checksum preamble fields
	localparam int OFF_W = 12;
	localparam int START_LSB = 0;
	localparam int INSERT_LSB = 16;
	// frame store
	localparam int DEPTH = 400;
	localparam int IDX_W = 9;
	localparam logic [IDX_W-1:0] HDR_WORDS = 9'h002;
	localparam int POS_W = 13;
	localparam logic [POS_W-1:0] POS_STEP = 13'h0004;
	typedef enum logic [2:0] {
		ST_CMD_A = 3'b000,
		ST_CMD_B = 3'b001,
		ST_PRE = 3'b010,
		ST_FILL = 3'b011,
		ST_FOLD = 3'b100,
		ST_SEND = 3'b101
	} state_e;
endpackage

//--- design/tx_sum_engine.sv
// transmit checksum offload engine: store, sum, insert and forward one frame at a time
// Notes on behaviour
// (RULE1) checksum is computed on the passing stream and written back into it
// (RULE2) host sets the offload enable bit before any offload happens
// (RULE3) offloaded frame is led by command A, command B, then a preamble word
// (RULE4) sum only when request flag, first-segment flag and enable are all set
// (RULE5) preamble bits 11:0 give the first summed byte; summing runs to frame end
// (RULE6) host keeps the start offset out of first 14 and last 4 bytes
// (RULE7) preamble bits 27:16 give where the two checksum bytes are overwritten
// (RULE8) host keeps the insert offset out of first 14 and last 4 bytes
// (RULE9) request flag clear in command B means the frame passes unchanged
// (RULE10) a partial checksum may be summed and then replaced by the result
// (RULE11) with offload enabled the preamble word is dropped, host counts it in length
// (RULE12) software flushes transmit path before toggling enable; request flag per frame
// (RULE13) engine mode changes only with transmit path off and link interface empty
// (RULE14) host places the preamble word on a word boundary
// (RULE15) host counts the preamble in buffer and packet lengths
// (RULE16) the preamble buffer carries no frame bytes
// (RULE17) 16-bit ones-complement summation; the complement of the sum is inserted
// (RULE18) a computed 0000 is inserted as is, never turned into all ones
// (RULE19) software avoids offload for UDP over IPv6
// (RULE20) second byte of each pair is the high byte; carries fold back in
// (RULE21) an odd trailing byte is padded with a zero high byte
// (RULE22) reserved preamble bits ignored; frame held until the checksum can be placed
`timescale 1ns/1ps
module tx_sum_engine (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [tx_sum_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// words from the transmit data fifo
	input wire logic [31:0] in_data_i,
	input wire logic [1:0] in_bytes_i,
	input wire logic in_last_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	// words toward the mac
	output logic [31:0] out_data_o,
	output logic [1:0] out_bytes_o,
	output logic out_last_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	import tx_sum_pkg::*;

	logic [1:0] ctrl, next_ctrl;
	logic [31:0] next_wb_dat;
	logic next_wb_ack;
	logic wb_hit;

	state_e state, next_state;
	logic [IDX_W-1:0] wr_idx, next_wr_idx;
	logic [IDX_W-1:0] rd_idx, next_rd_idx;
	logic [POS_W-1:0] fr_pos, next_fr_pos;
	logic [31:0] sum, next_sum;
	logic [15:0] csum, next_csum;
	logic [OFF_W-1:0] start, next_start;
	logic [OFF_W-1:0] loc, next_loc;
	logic en_frame, next_en_frame;
	logic first_seg, next_first_seg;
	logic do_sum, next_do_sum;
	logic [1:0] last_bytes, next_last_bytes;
	logic next_in_ready;
	logic [31:0] next_out_data;
	logic [1:0] next_out_bytes;
	logic next_out_last;
	logic next_out_valid;

	logic [31:0] mem [DEPTH];
	logic mem_we;
	logic accept;
	logic [31:0] word_add;
	logic [16:0] fold1;
	logic [16:0] fold2;
	logic [POS_W-1:0] rd_pos;
	logic [POS_W-1:0] p;
	logic [31:0] rd_word;

	// register decode; ack drops in the cycle after it was given
	always_comb begin
		next_ctrl = ctrl;
		next_wb_dat = 32'h0000_0000;
		wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
		next_wb_ack = wb_hit;
		if (wb_hit && wb_we_i && wb_adr_i == CTRL_ADDR && wb_sel_i[0]) begin
			// enable is software's to toggle only with the path flushed
			next_ctrl = wb_dat_i[1:0]; // RULE12 RULE13
		end
		if (wb_hit && !wb_we_i) begin
			case (wb_adr_i)
				CTRL_ADDR: next_wb_dat = {30'h0000_0000, ctrl};
				STATUS_ADDR: next_wb_dat = {csum, 15'h0000, state != ST_CMD_A};
				default: next_wb_dat = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= CTRL_RESET;
			wb_dat_o <= 32'h0000_0000;
			wb_ack_o <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			wb_dat_o <= next_wb_dat;
			wb_ack_o <= next_wb_ack;
		end
	end

	// byte contributions of the incoming word to the running sum
	always_comb begin
		word_add = 32'h0000_0000;
		p = fr_pos;
		for (int j = 0; j < 4; j++) begin
			p = fr_pos + POS_W'(j);
			if ((!in_last_i || 2'(j) <= in_bytes_i) && p >= {1'b0, start}) begin // RULE5
				// parity relative to the start decides low or high byte
				if (p[0] ^ start[0])
					word_add = word_add + {16'h0000, in_data_i[8*j +: 8], 8'h00}; // RULE20
				else
					word_add = word_add + {24'h00_0000, in_data_i[8*j +: 8]}; // RULE21
			end
		end
	end

	// end-around carry folding; the result is complemented, zero kept as zero
	assign fold1 = {1'b0, sum[15:0]} + {1'b0, sum[31:16]}; // RULE20
	assign fold2 = {1'b0, fold1[15:0]} + {16'h0000, fold1[16]};

	assign accept = in_valid_i && in_ready_o;
	assign rd_pos = {2'b00, rd_idx - HDR_WORDS, 2'b00};

	// outgoing word with the checksum bytes patched in
	always_comb begin
		rd_word = mem[rd_idx];
		if (do_sum && rd_idx >= HDR_WORDS) begin
			for (int j = 0; j < 4; j++) begin
				if (rd_pos + POS_W'(j) == {1'b0, loc})
					rd_word[8*j +: 8] = csum[7:0]; // RULE7 RULE10
				else if (rd_pos + POS_W'(j) == {1'b0, loc} + 13'h0001)
					rd_word[8*j +: 8] = csum[15:8]; // RULE7
			end
		end
	end

	// frame sequencer: parse header, fill store, fold, then forward
	always_comb begin
		next_state = state;
		next_wr_idx = wr_idx;
		next_rd_idx = rd_idx;
		next_fr_pos = fr_pos;
		next_sum = sum;
		next_csum = csum;
		next_start = start;
		next_loc = loc;
		next_en_frame = en_frame;
		next_first_seg = first_seg;
		next_do_sum = do_sum;
		next_last_bytes = last_bytes;
		next_in_ready = in_ready_o;
		next_out_data = out_data_o;
		next_out_bytes = out_bytes_o;
		next_out_last = out_last_o;
		next_out_valid = out_valid_o && !out_ready_i;
		mem_we = 1'b0;
		case (state)
			ST_CMD_A: begin
				// intake opens only once the last word of the previous frame has left
				next_in_ready = !next_out_valid;
				next_en_frame = ctrl[CTRL_EN_BIT];
				if (accept) begin
					mem_we = 1'b1;
					next_wr_idx = wr_idx + 9'h001;
					next_first_seg = in_data_i[CMD_A_FIRST_SEG_BIT];
					next_state = ST_CMD_B;
				end
			end
			ST_CMD_B: begin
				if (accept) begin
					mem_we = 1'b1;
					next_wr_idx = wr_idx + 9'h001;
					next_do_sum = en_frame && first_seg && in_data_i[CMD_B_SUM_REQ_BIT]; // RULE4 RULE9
					next_state = en_frame ? ST_PRE : ST_FILL;
				end
			end
			ST_PRE: begin
				if (accept) begin
					// preamble is consumed, never stored or sent; reserved bits unread
					next_start = in_data_i[START_LSB +: OFF_W]; // RULE5 RULE22
					next_loc = in_data_i[INSERT_LSB +: OFF_W]; // RULE7 RULE11
					next_state = ST_FILL;
				end
			end
			ST_FILL: begin
				if (accept) begin
					mem_we = wr_idx < 9'(DEPTH);
					next_wr_idx = mem_we ? wr_idx + 9'h001 : wr_idx;
					next_fr_pos = fr_pos + POS_STEP;
					if (do_sum)
						next_sum = sum + word_add; // RULE1 RULE17
				end
			end
			ST_FOLD: begin
				next_csum = ~fold2[15:0]; // RULE17 RULE18
				next_state = ST_SEND;
			end
			ST_SEND: begin
				// whole frame held so a late checksum can land in an early byte
				if (!out_valid_o || out_ready_i) begin // RULE22
					next_out_valid = 1'b1;
					next_out_data = rd_word; // RULE1
					next_out_last = rd_idx == wr_idx - 9'h001;
					next_out_bytes = next_out_last ? last_bytes : 2'h3;
					next_rd_idx = rd_idx + 9'h001;
					if (next_out_last) begin
						next_state = ST_CMD_A;
						next_wr_idx = 9'h000;
						next_rd_idx = 9'h000;
						next_fr_pos = 13'h0000;
						next_sum = 32'h0000_0000;
						next_do_sum = 1'b0;
					end
				end
			end
			default: next_state = ST_CMD_A;
		endcase
		// a last word in any intake state ends the frame
		if (accept && in_last_i) begin
			next_last_bytes = (state == ST_FILL || state == ST_CMD_A || state == ST_CMD_B)
				? in_bytes_i : 2'h3;
			next_in_ready = 1'b0;
			next_state = ST_FOLD;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_CMD_A;
			wr_idx <= 9'h000;
			rd_idx <= 9'h000;
			fr_pos <= 13'h0000;
			sum <= 32'h0000_0000;
			csum <= 16'h0000;
			start <= 12'h000;
			loc <= 12'h000;
			en_frame <= 1'b0;
			first_seg <= 1'b0;
			do_sum <= 1'b0;
			last_bytes <= 2'h3;
			in_ready_o <= 1'b0;
			out_data_o <= 32'h0000_0000;
			out_bytes_o <= 2'h3;
			out_last_o <= 1'b0;
			out_valid_o <= 1'b0;
		end else begin
			state <= next_state;
			wr_idx <= next_wr_idx;
			rd_idx <= next_rd_idx;
			fr_pos <= next_fr_pos;
			sum <= next_sum;
			csum <= next_csum;
			start <= next_start;
			loc <= next_loc;
			en_frame <= next_en_frame;
			first_seg <= next_first_seg;
			do_sum <= next_do_sum;
			last_bytes <= next_last_bytes;
			in_ready_o <= next_in_ready;
			out_data_o <= next_out_data;
			out_bytes_o <= next_out_bytes;
			out_last_o <= next_out_last;
			out_valid_o <= next_out_valid;
		end
	end

	// frame store; contents need no reset since indices gate every read
	always_ff @(posedge clk_i) begin
		if (mem_we)
			mem[wr_idx] <= in_data_i;
	end
endmodule

//--- tb/tx_sum_properties.sv
// port checker for the transmit checksum offload engine
`timescale 1ns/1ps
module tx_sum_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic in_last_i,
	input wire logic in_valid_i,
	input wire logic in_ready_o,
	input wire logic [31:0] out_data_o,
	input wire logic [1:0] out_bytes_o,
	input wire logic out_last_o,
	input wire logic out_valid_o,
	input wire logic out_ready_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// bus request and the last word of a frame taken
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_last_in; in_valid_i && in_ready_o && in_last_i; endsequence
	a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack missing");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray data");
	a_intake_stop: assert property (s_last_in |=> !in_ready_o) else $error("intake open");
	a_send_start: assert property (s_last_in |-> ##3 out_valid_o) else $error("late send");
	a_hold_word: assert property (out_valid_o && !out_ready_i |=>
		out_valid_o && $stable(out_data_o)) else $error("word lost");
	a_full_word: assert property (out_valid_o && !out_last_o |-> out_bytes_o == 2'h3)
		else $error("short word");
	a_no_overlap: assert property (out_valid_o |-> !in_ready_o) else $error("overlap");
endmodule
bind tx_sum_engine tx_sum_properties i_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_dat_o, .wb_ack_o, .in_last_i, .in_valid_i, .in_ready_o, .out_data_o, .out_bytes_o,
	.out_last_o, .out_valid_o, .out_ready_i);

//--- tb/mac_sink.sv
// mac side model: takes words with random stalls and keeps them
`timescale 1ns/1ps
module mac_sink (
	// clock
	input wire logic clk_i,
	// words from the engine
	input wire logic [31:0] data_i,
	input wire logic last_i,
	input wire logic [1:0] bytes_i,
	input wire logic valid_i,
	output logic ready_o
);
	logic [31:0] q [$];
	logic [1:0] lb = 2'h0;
	int lpos = 0;
	initial ready_o = 1'b0;
	// stalls keep the held-word path busy; the last word's place and size are kept
	always @(posedge clk_i) begin
		if (valid_i && ready_o) begin
			q.push_back(data_i);
			if (last_i) begin
				lb = bytes_i;
				lpos = q.size();
			end
		end
		ready_o <= ($urandom % 4) != 0;
	end
endmodule

//--- tb/testbench.sv
// self-checking bench of the transmit checksum offload engine
`timescale 1ns/1ps
module testbench;
	import tx_sum_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, in_data_i = 32'h0, out_data_o, r;
	logic [1:0] in_bytes_i = 2'h0, out_bytes_o;
	logic in_last_i = 1'b0, in_valid_i = 1'b0, wb_ack_o, in_ready_o, out_last_o, out_valid_o;
	logic out_ready_i;
	logic [7:0] fb [64];
	int n_errors = 0, n_compared = 0, cyc_n = 0, n;
	always #12.5 clk_i = ~clk_i;
	tx_sum_engine i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .in_data_i, .in_bytes_i, .in_last_i, .in_valid_i,
		.in_ready_o, .out_data_o, .out_bytes_o, .out_last_o, .out_valid_o, .out_ready_i);
	mac_sink i_mac (.clk_i, .data_i(out_data_o), .last_i(out_last_o), .bytes_i(out_bytes_o),
		.valid_i(out_valid_o), .ready_o(out_ready_i));
	task end_of_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one classic cycle; request held up to the edge that samples ack high
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1)
			@(posedge clk_i);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// word held until the edge at which ready is sampled high
	task put(input logic [31:0] d, input logic l, input logic [1:0] b);
		in_data_i <= d;
		in_last_i <= l;
		in_bytes_i <= b;
		in_valid_i <= 1'b1;
		@(posedge clk_i);
		while (in_ready_o !== 1'b1)
			@(posedge clk_i);
	endtask
	function automatic logic [15:0] cks(input int s, input int n);
		logic [16:0] a;
		a = 17'h0;
		for (int i = s; i < n; i += 2)
			a = a[15:0] + a[16] + {(i + 1 < n) ? fb[i + 1] : 8'h00, fb[i]};
		a = a[15:0] + a[16];
		return ~(a[15:0] + a[16]);
	endfunction
	// send one frame, then compare what reached the mac side
	task frame(input logic en, input logic fs, input logic rq, input int n, input int s,
		input int ins);
		logic [15:0] c;
		logic [31:0] ca, cb;
		int nw;
		c = cks(s, n);
		// length fields in the low bits count the preamble when offload is enabled
		ca = (32'(fs) << CMD_A_FIRST_SEG_BIT) | 32'(n + (en ? 4 : 0));
		cb = (32'(rq) << CMD_B_SUM_REQ_BIT) | 32'(n + (en ? 4 : 0));
		nw = (n + 3) / 4;
		i_mac.q.delete();
		i_mac.lpos = 0;
		put(ca, 1'b0, 2'h3);
		put(cb, 1'b0, 2'h3);
		if (en)
			put({4'hF, 12'(ins), 4'hF, 12'(s)}, 1'b0, 2'h3);
		for (int k = 0; k < nw; k++)
			put({fb[4*k+3], fb[4*k+2], fb[4*k+1], fb[4*k]}, k == nw - 1, 2'(n - 4 * k - 1));
		in_valid_i <= 1'b0;
		while (i_mac.q.size() < nw + 2)
			@(posedge clk_i);
		chk(32'(i_mac.lpos), 32'(nw + 2));
		chk(32'(i_mac.lb), 32'((n - 1) % 4));
		chk(i_mac.q[0], ca);
		chk(i_mac.q[1], cb);
		if (en && fs && rq) begin
			fb[ins] = c[7:0];
			fb[ins + 1] = c[15:8];
		end
		for (int k = 0; k < n; k++)
			chk(32'(i_mac.q[2 + k / 4][8 * (k % 4) +: 8]), 32'(fb[k]));
	endtask
	task fill;
		for (int i = 0; i < 64; i++)
			fb[i] = 8'($urandom);
	endtask
	// hang guard
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			n_errors++;
			end_of_test;
		end
	end
	initial begin
		void'($urandom(6030));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b1, CTRL_ADDR, 32'h3);
		wb(1'b0, CTRL_ADDR, 32'h0);
		chk(r, 32'h3);
		wb(1'b0, 8'h80, 32'h0);
		chk(r, 32'h0);
		wb(1'b1, CTRL_ADDR, 32'h0);
		fill;
		frame(1'b0, 1'b1, 1'b1, 40, 14, 30);
		wb(1'b1, CTRL_ADDR, 32'h1);
		for (int i = 0; i < 8; i++) begin
			n = 20 + $urandom % 41;
			fill;
			frame(1'b1, i != 1, i != 2, n,
				14 + $urandom % (n - 19), 14 + $urandom % (n - 19));
		end
		// partial sum chosen so the result is zero
		fill;
		{fb[21], fb[20]} = 16'h0;
		{fb[21], fb[20]} = cks(14, 41);
		frame(1'b1, 1'b1, 1'b1, 41, 14, 20);
		wb(1'b0, STATUS_ADDR, 32'h0);
		chk(32'(r[31:16]), 32'h0);
		chk(32'(r[0]), 32'h0);
		end_of_test;
	end
endmodule
